// ---- rtl/vdim_top.sv ----
// Virtual digital input mux: level registers, source selects, duplicate alarm
//
// Function
// - Channel 1 select of 1 takes its level from virtual level register 1.
// - Virtual level register value 0 means low, 1 means high.
// - Channels 2 to 8 each own a select and level register, same substitution.
// - Alarm whenever two virtual inputs share the same non-zero function code.
// - Each virtual input carries any assignable function, as a hardware terminal.
// - Four-terminal variant omits virtual channels 5 to 8 and their registers.
`timescale 1ns/10ps
`default_nettype none
module vdim_top
	import vdim_pkg::*;
#(
	parameter int NCH    = VDIM_MAX_CH,
	parameter int FUNC_W = VDIM_FUNC_W
) (
	input  wire logic                   MCLK_I,
	input  wire logic                   SRST_I,
	input  wire logic [VDIM_ADDR_W-1:0] ADDR_I,
	input  wire logic [VDIM_DATA_W-1:0] WDATA_I,
	input  wire logic                   WR_I,
	input  wire logic                   RD_I,
	output logic      [VDIM_DATA_W-1:0] RDATA_O,
	input  wire logic [NCH-1:0]         HW_TERM_I,
	output logic      [NCH-1:0]         DI_CHAN_O,
	output logic      [NCH*FUNC_W-1:0]  DI_FUNC_O,
	output logic                        DUP_ALARM_O
);

	// Register offset of a channel within a bank
	function automatic logic [VDIM_ADDR_W-1:0] chan_addr(
		input logic [7:0] base,
		input int         ch
	);
		chan_addr = base + 8'(ch * int'(VDIM_CHAN_STRIDE));
	endfunction

	logic [NCH-1:0]        level;
	logic [NCH-1:0]        src_sel;
	logic [NCH*FUNC_W-1:0] func;
	logic [NCH-1:0]        hw_meta;
	logic [NCH-1:0]        hw_sync;
	logic [NCH-1:0]        next_chan;
	logic                  dup_now;
	logic [NCH-1:0]        hit_level;
	logic [NCH-1:0]        hit_sel;
	logic [NCH-1:0]        hit_func;
	logic [VDIM_DATA_W-1:0] next_rdata;
	logic [VDIM_DATA_W-1:0] rd_chan;
	wire                   hit_status = (ADDR_I == VDIM_STATUS);
	wire                   hit_inputs = (ADDR_I == VDIM_INPUTS);

	// Terminals arrive from pins; two flops before any use
	always_ff @(posedge MCLK_I) begin
		if (SRST_I) begin
			hw_meta <= '0;
			hw_sync <= '0;
		end else begin
			hw_meta <= HW_TERM_I;
			hw_sync <= hw_meta;
		end
	end

	// Per-channel registers; NCH of 4 simply builds no channels 5 to 8
	genvar c;
	generate
		for (c = 0; c < NCH; c++) begin : g_ch
			assign hit_level[c] = (ADDR_I == chan_addr(VDIM_LEVEL_BASE, c));
			assign hit_sel[c]   = (ADDR_I == chan_addr(VDIM_SEL_BASE, c));
			assign hit_func[c]  = (ADDR_I == chan_addr(VDIM_FUNC_BASE, c));

			always_ff @(posedge MCLK_I) begin
				if (SRST_I) begin
					level[c]                   <= VDIM_LEVEL_RST;
					src_sel[c]                 <= VDIM_SEL_RST;
					func[c*FUNC_W +: FUNC_W]   <= VDIM_FUNC_RST;
				end else if (WR_I) begin
					if (hit_level[c])
						level[c] <= WDATA_I[0];
					if (hit_sel[c])
						src_sel[c] <= WDATA_I[0];
					if (hit_func[c])
						func[c*FUNC_W +: FUNC_W] <= WDATA_I[FUNC_W-1:0];
				end
			end

			// Virtual level replaces the terminal only when selected
			assign next_chan[c] = (src_sel[c] == VDIM_SRC_VIRTUAL) ? level[c]
			                                                       : hw_sync[c];
		end
	endgenerate

	// Duplicate check over the function codes; one code per channel
	vdim_dup_check #(
		.NCH    (NCH),
		.FUNC_W (FUNC_W)
	) u_dup (
		.func_i (func),
		.dup_o  (dup_now)
	);

	// Read mux: one-hot per bank, low bits only, upper bits zero
	always_comb begin
		rd_chan = '0;
		for (int i = 0; i < NCH; i++) begin
			if (hit_level[i])
				rd_chan = rd_chan | VDIM_DATA_W'(level[i]);
			if (hit_sel[i])
				rd_chan = rd_chan | VDIM_DATA_W'(src_sel[i]);
			if (hit_func[i])
				rd_chan = rd_chan | VDIM_DATA_W'(func[i*FUNC_W +: FUNC_W]);
		end
	end

	assign next_rdata = hit_status ? (VDIM_DATA_W'(dup_now) << VDIM_ST_DUP_BIT) |
	                                 (VDIM_DATA_W'(NCH) << VDIM_ST_NCH_LSB)
	                  : hit_inputs ? VDIM_DATA_W'(DI_CHAN_O)
	                  : rd_chan; // Unmapped addresses read zero

	// Read data stands only in the cycle after the strobe
	always_ff @(posedge MCLK_I) begin
		if (SRST_I)
			RDATA_O <= '0;
		else if (RD_I)
			RDATA_O <= next_rdata;
		else
			RDATA_O <= '0;
	end

	// Outputs registered; alarm is a level that follows the configuration
	always_ff @(posedge MCLK_I) begin
		if (SRST_I) begin
			DI_CHAN_O   <= '0;
			DI_FUNC_O   <= '0;
			DUP_ALARM_O <= 1'b0;
		end else begin
			DI_CHAN_O   <= next_chan;
			DI_FUNC_O   <= func;
			DUP_ALARM_O <= dup_now;
		end
	end

endmodule // vdim_top
`default_nettype wire

// ---- rtl/vdim_pkg.sv ----
// Package: register map, field layout and reset values of the virtual input mux
package vdim_pkg;

	localparam int          VDIM_ADDR_W      = 8;
	localparam int          VDIM_DATA_W      = 32;
	localparam int          VDIM_MAX_CH      = 8;
	localparam int          VDIM_FUNC_W      = 8;

	// Byte offsets: level registers, source selects, function codes, status
	localparam logic [7:0]  VDIM_LEVEL_BASE  = 8'h00;
	localparam logic [7:0]  VDIM_SEL_BASE    = 8'h20;
	localparam logic [7:0]  VDIM_FUNC_BASE   = 8'h40;
	localparam logic [7:0]  VDIM_STATUS      = 8'h60;
	localparam logic [7:0]  VDIM_INPUTS      = 8'h64;
	localparam logic [7:0]  VDIM_CHAN_STRIDE = 8'h04;

	// Status field positions
	localparam int          VDIM_ST_DUP_BIT  = 0;
	localparam int          VDIM_ST_NCH_LSB  = 8;

	// Reset values
	localparam logic        VDIM_LEVEL_RST   = 1'h0;
	localparam logic        VDIM_SEL_RST     = 1'h0;
	localparam logic [7:0]  VDIM_FUNC_RST    = 8'h00;

	// Source select encoding
	localparam logic        VDIM_SRC_HW      = 1'h0;
	localparam logic        VDIM_SRC_VIRTUAL = 1'h1;

	// Level encoding
	localparam logic        VDIM_LVL_LOW     = 1'h0;
	localparam logic        VDIM_LVL_HIGH    = 1'h1;

endpackage

// ---- rtl/vdim_dup_check.sv ----
// Duplicate non-zero function code detector over all virtual inputs
`timescale 1ns/10ps
`default_nettype none
module vdim_dup_check
	import vdim_pkg::*;
#(
	parameter int NCH    = 8,
	parameter int FUNC_W = 8
) (
	input  wire logic [NCH*FUNC_W-1:0] func_i,
	output logic                       dup_o
);

	logic [NCH*NCH-1:0] pair_hit;

	// Every unordered pair compared; zero means unassigned and never clashes
	genvar a, b;
	generate
		for (a = 0; a < NCH; a++) begin : g_a
			for (b = 0; b < NCH; b++) begin : g_b
				if (b > a) begin : g_cmp
					assign pair_hit[a*NCH+b] =
						(func_i[a*FUNC_W +: FUNC_W] != '0) &&
						(func_i[a*FUNC_W +: FUNC_W] == func_i[b*FUNC_W +: FUNC_W]);
				end else begin : g_none
					assign pair_hit[a*NCH+b] = 1'b0;
				end
			end
		end
	endgenerate

	assign dup_o = |pair_hit;

endmodule // vdim_dup_check
`default_nettype wire

// ---- tb/vdim_sva.sv ----
// Checker of the mux bus and alarm
`timescale 1ns/10ps
`default_nettype none
module vdim_sva
	import vdim_pkg::*;
#(parameter int NCH = 8) (
	input wire logic           MCLK_I,
	input wire logic           SRST_I,
	input wire logic [7:0]     ADDR_I,
	input wire logic [31:0]    WDATA_I,
	input wire logic           WR_I,
	input wire logic           RD_I,
	input wire logic [31:0]    RDATA_O,
	input wire logic [NCH-1:0] DI_CHAN_O,
	input wire logic           DUP_ALARM_O
);
	// One domain, so clock and reset are stated once
	default clocking @(posedge MCLK_I); endclocking
	default disable iff (SRST_I);
	a_rdata_idle: assert property (!RD_I |=> RDATA_O == 0)
		else $error("read data without read");
	a_level_back: assert property (WR_I && ADDR_I == 0 ##1 RD_I && ADDR_I == 0
		|=> RDATA_O[0] == $past(WDATA_I[0], 2)) else $error("level read back");
	a_chan_read: assert property (RD_I && ADDR_I == VDIM_INPUTS
		|=> RDATA_O[NCH-1:0] == $past(DI_CHAN_O)) else $error("channel read");
	// Status shows the live compare, which the alarm flop also takes at the read edge
	a_dup_read: assert property (RD_I && ADDR_I == VDIM_STATUS
		|=> RDATA_O[0] == DUP_ALARM_O) else $error("status read");
	// A code write moves the alarm two samples later, so look one cycle further on
	a_dup_quiet: assert property (!WR_I |-> ##2 $stable(DUP_ALARM_O))
		else $error("alarm moved without write");
	a_unmapped_rd: assert property (RD_I && ADDR_I > 8'h64 |=> RDATA_O == 0)
		else $error("unmapped read");
	a_narrow_rd: assert property (RD_I && ADDR_I < 8'h40 |=> RDATA_O[31:1] == 0)
		else $error("wide level read");
endmodule // vdim_sva
bind vdim_top vdim_sva #(.NCH(NCH)) u_sva (.*);
`default_nettype wire

// ---- tb/vdim_term_model.sv ----
// Terminal wiring model
`timescale 1ns/10ps
`default_nettype none
module vdim_term_model (
	input  wire logic       clk_i,
	input  wire logic [7:0] lvl_i,
	output logic      [7:0] term_o
);
	// Terminals settle a cycle late
	always_ff @(posedge clk_i) begin
		term_o <= lvl_i;
	end
endmodule // vdim_term_model
`default_nettype wire

// ---- tb/tb_top.sv ----
// Bench of the mux
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	import vdim_pkg::*;
	logic clk = 0, rst = 1, wr = 0, rd = 0, pend = 0;
	logic [7:0] addr = 0, hw = 0, term, di;
	logic [31:0] wd = 0, rdat, s = 19, q[$];
	logic [63:0] fo;
	logic dup, dup4;
	logic [31:0] rdat4, fo4;
	logic [3:0] di4;
	int fails = 0, total_checks = 0;
	vdim_top u_dut (.MCLK_I(clk), .SRST_I(rst), .ADDR_I(addr), .WDATA_I(wd),
		.WR_I(wr), .RD_I(rd), .RDATA_O(rdat), .HW_TERM_I(term),
		.DI_CHAN_O(di), .DI_FUNC_O(fo), .DUP_ALARM_O(dup));
	vdim_term_model u_term (.clk_i(clk), .lvl_i(hw), .term_o(term));
	// Four-terminal variant on the same bus: channels 5 to 8 must not exist
	vdim_top #(.NCH(4)) u_dut4 (.MCLK_I(clk), .SRST_I(rst), .ADDR_I(addr), .WDATA_I(wd),
		.WR_I(wr), .RD_I(rd), .RDATA_O(rdat4), .HW_TERM_I(term[3:0]),
		.DI_CHAN_O(di4), .DI_FUNC_O(fo4), .DUP_ALARM_O(dup4));
	initial forever #2.5 clk = ~clk;
	function automatic logic [31:0] xs(logic [31:0] v);
		v ^= v << 13;
		v ^= v >> 17;
		return v ^ (v << 5);
	endfunction
	task automatic chk(logic [31:0] seen, logic [31:0] exp, string nm);
		total_checks++;
		if (seen !== exp) begin
			fails++;
			$display("wrong value %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	// Strobe stays up until the next call, so cycles run back to back
	task automatic bus(logic w, logic r, logic [7:0] a, logic [31:0] d);
		@(posedge clk);
		wr <= w;
		rd <= r;
		addr <= a;
		wd <= d;
		if (r) q.push_back(d);
	endtask
	task automatic end_of_test;
		$display("checks %0d fails %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// Outputs are compared at the falling edge, clear of the edge that moves them
	task automatic look(logic [7:0] ch, logic dp, logic [63:0] fn, logic dp4);
		@(negedge clk);
		chk(32'(di), 32'(ch), "channels");
		chk(32'(di4), 32'(ch[3:0]), "short channels");
		chk(32'(dup), 32'(dp), "alarm");
		chk(32'(dup4), 32'(dp4), "short alarm");
		chk(fo[31:0], fn[31:0], "functions low");
		chk(fo[63:32], fn[63:32], "functions high");
		chk(fo4, fn[31:0], "short functions");
	endtask
	// Read data are settled at the falling edge
	always @(negedge clk) begin
		if (pend) chk(rdat, q.pop_front(), "rdata");
		pend = rd;
	end
	initial begin
		logic [7:0] sel, lvl, f[8], e, h;
		logic dx, dx4;
		repeat (2) @(posedge clk);
		rst <= 0;
		for (int c = 0; c < 24; c++) bus(0, 1, 8'(4*c), 0);
		bus(0, 1, VDIM_STATUS, 32'h800);
		bus(0, 1, 8'h80, 0);
		look(8'h0, 1'b0, 64'h0, 1'b0);
		repeat (20) begin
			s = xs(s);
			sel = s[7:0];
			lvl = s[15:8];
			h = s[23:16];
			e = (sel & lvl) | (~sel & h);
			s = xs(s);
			dx = 0;
			dx4 = 0;
			// Two-bit codes make repeated functions common
			for (int c = 0; c < 8; c++) begin
				f[c] = {6'h0, s[2*c+:2]};
				for (int k = 0; k < c; k++) begin
					dx |= f[c] != 0 && f[c] == f[k];
					dx4 |= c < 4 && f[c] != 0 && f[c] == f[k];
				end
				bus(1, 0, VDIM_SEL_BASE + 8'(4*c), sel[c]);
				// Terminals move right after a rising edge, early enough to cross the synchroniser
				if (c == 0) hw <= h;
				bus(1, 0, 8'(4*c), lvl[c]);
				bus(0, 1, 8'(4*c), lvl[c]);
				bus(1, 0, VDIM_FUNC_BASE + 8'(4*c), f[c]);
			end
			bus(0, 1, VDIM_INPUTS, e);
			bus(0, 1, VDIM_STATUS, {16'h0, 8'h08, 7'h0, dx});
			bus(0, 1, VDIM_FUNC_BASE + 8'(4*s[18:16]), f[s[18:16]]);
			look(e, dx, {f[7], f[6], f[5], f[4], f[3], f[2], f[1], f[0]}, dx4);
		end
		bus(0, 0, 0, 0);
		bus(0, 0, 0, 0);
		end_of_test();
	end
	initial begin
		#20000;
		fails++;
		end_of_test();
	end
endmodule // tb_top
`default_nettype wire
